/* common/oag_params.svh */
`ifndef OAG_PARAMS_SVH
`define OAG_PARAMS_SVH
// instruction and control word fields, bit n of the word sits at index n-1
`define OAG_IA_BIT      24
`define OAG_X_HI        23
`define OAG_X_LO        20
`define OAG_OP_HI       19
`define OAG_OP_LO       14
`define OAG_TYPE_HI     19
`define OAG_TYPE_LO     17
`define OAG_RD_HI       13
`define OAG_RD_LO       10
`define OAG_M_HI        9
`define OAG_L_HI        14
// first optional index register
`define OAG_OPT_X       4'hA
`define OAG_ALL_ONES    15'h7FFF
// apb byte offsets
`define OAG_CTRL        12'h000
`define OAG_INSTR       12'h004
`define OAG_STATUS      12'h008
`define OAG_RESULT      12'h00C
`define OAG_CHAIN       12'h010
`define OAG_INT_STAT    12'h014
`define OAG_INT_CLR     12'h018
`define OAG_INT_EN      12'h01C
`define OAG_SAVE        12'h020
`define OAG_IDX_BASE    6'h01
// control bits
`define OAG_CTRL_START  0
`define OAG_CTRL_FIT15  1
// event bits
`define OAG_EV_DONE     0
`define OAG_EV_FIELD_SELECT_CONTROL_WORD     1
`endif

/* common/oag_pkg.sv */
package oag_pkg;
  // resolver states, gray along idle-fetch-done
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_DONE  = 2'b11,
    ST_FIELD_SELECT_CONTROL_WORD  = 2'b10
  } state_t;
  // request towards core memory
  typedef struct packed {
    logic        req;
    logic [14:0] addr;
  } mem_req_t;
  // field select hand-off
  typedef struct packed {
    logic        valid;
    logic [24:0] word;
    logic [14:0] addr;
  } field_select_control_word_t;
  // operand description for the datapath
  typedef struct packed {
    logic             valid;
    logic [5:0]       op;
    logic [14:0]      addr;
    logic [4:1]       sel;
    logic [4:1][14:0] word_addr;
    logic [4:1]       sign_src;
    logic [4:1]       ovf_reg;
    logic [3:0]       extra;
  } oper_t;
  // whole block state
  typedef struct packed {
    state_t           st;
    logic [24:0]      instr;
    logic             fit15;
    logic [15:1][14:0] idx;
    logic [14:0]      maddr;
    logic [7:0]       chain;
    logic [1:0]       ev;
    logic [1:0]       ev_en;
    logic [24:0]      save;
    logic             irq;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    mem_req_t         mem;
    field_select_control_word_t            field_select_control_word;
    oper_t            oper;
  } core_t;
endpackage

/* src/operand_address_generator.sv */
`timescale 1ns/1ps
`include "oag_params.svh"

module operand_address_generator (
  // apb slave
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic [31:0]           prdata,
  // core memory
  output oag_pkg::mem_req_t     mem_out,
  input  wire logic             mem_ack,
  input  wire logic [24:0]      mem_rdata,
  // field selection logic
  output oag_pkg::field_select_control_word_t        field_select_control_word_out,
  // execution datapath
  output oag_pkg::oper_t        oper_out,
  // interrupt
  output logic                  irq
);

  oag_pkg::core_t st_ff;   // registered state
  oag_pkg::core_t nxt_st;  // next state

  // indexed address, carry beyond 15 bits dropped
  function automatic logic [14:0] index_add(input logic [14:0] base,
                                            input logic [3:0]  x,
                                            input oag_pkg::core_t s);
    logic [14:0] v;
    v = 15'h0000;
    if (x >= `OAG_OPT_X && !s.fit15) begin
      v = `OAG_ALL_ONES;
    end else if (x != 4'h0) begin
      v = s.idx[x];
    end
    return base + v;
  endfunction

  // per-register word addresses and end markers
  logic [4:1][14:0] wa;   // word address per accumulator
  logic [4:1]       lsr;  // highest-numbered selected
  logic [4:1]       msr;  // lowest-numbered selected
  logic [2:0]       nsel; // words in operand
  logic [4:1]       dsg;  // designator in register order

  assign dsg = {st_ff.instr[`OAG_RD_LO], st_ff.instr[`OAG_RD_LO+1],
                st_ff.instr[`OAG_RD_LO+2], st_ff.instr[`OAG_RD_HI]};

  genvar g;
  generate
    for (g = 1; g <= 4; g++) begin : g_acc
      logic [2:0] above;  // selected registers numbered higher
      logic [2:0] below;  // selected registers numbered lower
      always_comb begin
        above = 3'h0;
        below = 3'h0;
        for (int k = 1; k <= 4; k++) begin
          if (k > g && dsg[k]) above = above + 3'h1;
          if (k < g && dsg[k]) below = below + 3'h1;
        end
      end
      // lower memory addresses for lower-numbered registers
      assign wa[g]  = dsg[g] ? st_ff.maddr - {12'h000, above} : 15'h0000;
      assign lsr[g] = dsg[g] && (above == 3'h0);  // sign source
      assign msr[g] = dsg[g] && (below == 3'h0);  // overflow point
    end
  endgenerate

  assign nsel = {2'b00, dsg[1]} + {2'b00, dsg[2]} + {2'b00, dsg[3]} + {2'b00, dsg[4]};

  // apb decode
  logic        setup;   // setup phase of a transfer
  logic        wr;      // write taking effect
  logic [3:0]  xsel;    // index register number from address
  logic        idx_hit; // address in index window

  assign setup   = psel && !penable;
  assign wr      = psel && penable && pwrite;
  assign xsel    = paddr[5:2];
  assign idx_hit = (paddr[11:6] == `OAG_IDX_BASE) && (xsel != 4'h0) && (paddr[1:0] == 2'b00);

  // next state
  always_comb begin
    logic [14:0] a;     // freshly indexed address
    logic        start; // software start
    a = 15'h0000;
    start = 1'b0;
    nxt_st = st_ff;
    nxt_st.pready = 1'b1;
    nxt_st.field_select_control_word.valid = 1'b0;
    nxt_st.oper.valid = 1'b0;

    // read data latched in setup, answered in access
    if (setup) begin
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata  = 32'h0000_0000;
      if (idx_hit) begin
        nxt_st.prdata = {17'h00000, st_ff.idx[xsel]};
      end else begin
        case (paddr)
          `OAG_CTRL:     nxt_st.prdata = {30'h0, st_ff.fit15, 1'b0};
          `OAG_INSTR:    nxt_st.prdata = {7'h00, st_ff.instr};
          `OAG_STATUS:   nxt_st.prdata = {29'h0, st_ff.st, st_ff.st != oag_pkg::ST_IDLE};
          `OAG_RESULT:   nxt_st.prdata = {17'h00000, st_ff.maddr};
          `OAG_CHAIN:    nxt_st.prdata = {24'h000000, st_ff.chain};
          `OAG_INT_STAT: nxt_st.prdata = {30'h0, st_ff.ev};
          `OAG_INT_CLR:  nxt_st.prdata = 32'h0000_0000;
          `OAG_INT_EN:   nxt_st.prdata = {30'h0, st_ff.ev_en};
          `OAG_SAVE:     nxt_st.prdata = {7'h00, st_ff.save};
          default:       nxt_st.pslverr = 1'b1;
        endcase
      end
    end

    // writes take effect at the completing edge
    if (wr) begin
      if (idx_hit) begin
        nxt_st.idx[xsel] = pwdata[14:0];
      end else begin
        case (paddr)
          `OAG_CTRL: begin
            nxt_st.fit15 = pwdata[`OAG_CTRL_FIT15];
            start = pwdata[`OAG_CTRL_START];
          end
          `OAG_INSTR: begin
            if (st_ff.st == oag_pkg::ST_IDLE) nxt_st.instr = pwdata[24:0];
          end
          `OAG_INT_CLR: nxt_st.ev = st_ff.ev & ~pwdata[1:0];
          `OAG_INT_EN:  nxt_st.ev_en = pwdata[1:0];
          // counter reading in bits 1-15, bits 16-25 cleared
          `OAG_SAVE:    nxt_st.save = {10'h000, pwdata[14:0]};
          default: begin
          end
        endcase
      end
    end

    // address resolution
    case (st_ff.st)
      oag_pkg::ST_IDLE: begin
        if (start) begin
          // index in the same cycle as decode
          a = index_add({5'h00, st_ff.instr[`OAG_M_HI:0]},
                        st_ff.instr[`OAG_X_HI:`OAG_X_LO], st_ff);
          nxt_st.maddr = a;
          nxt_st.chain = 8'h00;
          if (st_ff.instr[`OAG_IA_BIT]) begin
            nxt_st.mem.req  = 1'b1;
            nxt_st.mem.addr = a;
            nxt_st.st = oag_pkg::ST_FETCH;
          end else begin
            nxt_st.st = oag_pkg::ST_DONE;
          end
        end
      end
      oag_pkg::ST_FETCH: begin
        if (mem_ack) begin
          a = index_add(mem_rdata[`OAG_L_HI:0],
                        mem_rdata[`OAG_X_HI:`OAG_X_LO], st_ff);
          nxt_st.mem.req = 1'b0;
          if (mem_rdata[`OAG_IA_BIT]) begin
            // one more level, one more memory cycle
            nxt_st.chain    = st_ff.chain + 8'h01;
            nxt_st.maddr    = a;
            nxt_st.mem.req  = 1'b1;
            nxt_st.mem.addr = a;
          end else if (mem_rdata[`OAG_TYPE_HI:`OAG_TYPE_LO] == 3'b000) begin
            nxt_st.chain = st_ff.chain + 8'h01;
            nxt_st.maddr = a;
            nxt_st.st = oag_pkg::ST_DONE;
          end else begin
            // not an address: hand word and its location on
            nxt_st.field_select_control_word.valid = 1'b1;
            nxt_st.field_select_control_word.word  = mem_rdata;
            nxt_st.field_select_control_word.addr  = st_ff.mem.addr;
            nxt_st.st = oag_pkg::ST_FIELD_SELECT_CONTROL_WORD;
          end
        end
      end
      oag_pkg::ST_DONE: begin
        nxt_st.oper.valid = 1'b1;
        nxt_st.oper.op    = st_ff.instr[`OAG_OP_HI:`OAG_OP_LO];
        nxt_st.oper.addr  = st_ff.maddr;
        nxt_st.oper.sel   = dsg;
        nxt_st.oper.word_addr = wa;
        nxt_st.oper.sign_src  = lsr;
        nxt_st.oper.ovf_reg   = msr;
        nxt_st.oper.extra = (nsel == 3'h0) ? 4'h0 : {1'b0, nsel - 3'h1};
        nxt_st.st = oag_pkg::ST_IDLE;
      end
      oag_pkg::ST_FIELD_SELECT_CONTROL_WORD: begin
        nxt_st.st = oag_pkg::ST_IDLE;
      end
      default: nxt_st.st = oag_pkg::ST_IDLE;
    endcase

    // sticky events, set wins over clear
    if (st_ff.st == oag_pkg::ST_DONE) nxt_st.ev[`OAG_EV_DONE] = 1'b1;
    if (st_ff.st == oag_pkg::ST_FIELD_SELECT_CONTROL_WORD) nxt_st.ev[`OAG_EV_FIELD_SELECT_CONTROL_WORD] = 1'b1;
    nxt_st.irq = |(nxt_st.ev & nxt_st.ev_en);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign pready   = st_ff.pready;
  assign pslverr  = st_ff.pslverr;
  assign prdata   = st_ff.prdata;
  assign mem_out  = st_ff.mem;
  assign field_select_control_word_out = st_ff.field_select_control_word;
  assign oper_out = st_ff.oper;
  assign irq      = st_ff.irq;

  // checks
  property p_noidx;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.st == oag_pkg::ST_IDLE && nxt_st.st == oag_pkg::ST_DONE
       && st_ff.instr[`OAG_X_HI:`OAG_X_LO] == 4'h0)
      |=> st_ff.maddr == {5'h00, $past(st_ff.instr[`OAG_M_HI:0])};
  endproperty
  a_noidx: assert property (p_noidx) else $error("unindexed address wrong");

  property p_absent;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.st == oag_pkg::ST_IDLE && nxt_st.st != oag_pkg::ST_IDLE && !st_ff.fit15
       && st_ff.instr[`OAG_X_HI:`OAG_X_LO] >= `OAG_OPT_X)
      |=> st_ff.maddr == $past(st_ff.instr[`OAG_M_HI:0]) - 15'h0001;
  endproperty
  a_absent: assert property (p_absent) else $error("absent index not all ones");

  property p_instr_kept;
    @(posedge pclk) disable iff (!presetn)
      st_ff.st != oag_pkg::ST_IDLE |=> $stable(st_ff.instr);
  endproperty
  a_instr_kept: assert property (p_instr_kept) else $error("instruction altered");

  property p_ia_fetch;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.st == oag_pkg::ST_IDLE && nxt_st.st != oag_pkg::ST_IDLE)
      |=> (st_ff.mem.req == $past(st_ff.instr[`OAG_IA_BIT]));
  endproperty
  a_ia_fetch: assert property (p_ia_fetch) else $error("indirect flag ignored");

  property p_chain;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.st == oag_pkg::ST_FETCH && mem_ack && mem_rdata[`OAG_IA_BIT])
      |=> st_ff.mem.req && st_ff.st == oag_pkg::ST_FETCH
          && st_ff.chain == $past(st_ff.chain) + 8'h01;
  endproperty
  a_chain: assert property (p_chain) else $error("chain not followed");

  property p_field_select_control_word;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.st == oag_pkg::ST_FETCH && mem_ack && !mem_rdata[`OAG_IA_BIT]
       && mem_rdata[`OAG_TYPE_HI:`OAG_TYPE_LO] != 3'b000)
      |=> field_select_control_word_out.valid && field_select_control_word_out.addr == $past(st_ff.mem.addr) ##1 !oper_out.valid;
  endproperty
  a_field_select_control_word: assert property (p_field_select_control_word) else $error("field select not handed off");

  property p_pairing;
    @(posedge pclk) disable iff (!presetn)
      (oper_out.valid && oper_out.sel[4]) |-> oper_out.word_addr[4] == oper_out.addr;
  endproperty
  a_pairing: assert property (p_pairing) else $error("lsw not on top register");

  property p_extra;
    @(posedge pclk) disable iff (!presetn)
      (oper_out.valid && oper_out.sel == 4'hF) |-> oper_out.extra == 4'h3
      && oper_out.sign_src == 4'h8 && oper_out.ovf_reg == 4'h1;
  endproperty
  a_extra: assert property (p_extra) else $error("multiword figures wrong");

  property p_save;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `OAG_SAVE) |=> st_ff.save[24:15] == 10'h000;
  endproperty
  a_save: assert property (p_save) else $error("save word upper bits set");

endmodule // operand_address_generator

/* bench/core_mem_model.sv */
`timescale 1ns/1ps
// behavioural core memory answering word reads after a set delay
module core_mem_model (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // read request from the block and wait setting
  input  wire oag_pkg::mem_req_t mem_in,
  input  wire logic [3:0]        lat,
  // read answer
  output logic                   mem_ack,
  output logic [24:0]            mem_rdata
);
  logic [24:0] mem [0:63]; // word store, low address bits only
  logic [3:0]  cnt_ff;     // cycles waited on the current request
  // one-cycle ack with data; outside it the data lines keep toggling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 25'h0000000;
      cnt_ff    <= 4'h0;
    end else if (mem_ack) begin
      // request consumed, never answer it twice
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_in.req && cnt_ff >= lat) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem[mem_in.addr[5:0]];
      cnt_ff    <= 4'h0;
    end else begin
      cnt_ff    <= mem_in.req ? cnt_ff + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // core_mem_model

/* bench/tb.sv */
`timescale 1ns/1ps
`include "oag_params.svh"
// bench: apb tasks drive the block, memory model answers control words
module tb;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic              pready;
  logic              pslverr;
  logic [31:0]       prdata;
  logic              mem_ack;
  logic [24:0]       mem_rdata;
  logic [3:0]        lat;        // memory wait cycles
  logic              irq;
  oag_pkg::mem_req_t mem_out;
  oag_pkg::field_select_control_word_t    field_select_control_word_out;
  oag_pkg::oper_t    oper_out;
  int                err_count;
  int                checks_done;
  int                n;          // edges waited for an event
  logic [14:0]       idx [1:15]; // index register contents
  logic [31:0]       rd;         // last read data
  logic              er;         // last error response
  logic [24:0]       ins;        // instruction under test
  logic [9:0]        m;
  logic [3:0]        r;
  logic [5:0]        op;
  logic [14:0]       ea;

  operand_address_generator u_operand_address_generator (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .mem_out, .mem_ack, .mem_rdata,
    .field_select_control_word_out, .oper_out, .irq);
  core_mem_model u_core_mem_model (.pclk, .presetn, .mem_in(mem_out), .lat, .mem_ack,
    .mem_rdata);

  // free running clock
  always #10 pclk = ~pclk;

  // compare and count
  task automatic chk(input string nm, input logic [127:0] s, input logic [127:0] x);
    checks_done++;
    if (s !== x) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask

  // verdict and end of run
  task automatic conclude();
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_count++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // load instruction, start, wait for hand-off of either kind
  task automatic run(input logic [24:0] i, input logic fit);
    apb(1'b1, `OAG_INSTR, 32'(i));
    apb(1'b1, `OAG_CTRL, {30'h0, fit, 1'b1});
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (oper_out.valid !== 1'b1 && field_select_control_word_out.valid !== 1'b1 && n < 60);
    if (n >= 60) begin
      err_count++;
      conclude();
    end
  endtask

  // expected operand description for address a and designator s
  function automatic oag_pkg::oper_t exp_oper(input logic [5:0] o, input logic [14:0] a,
                                              input logic [3:0] s);
    oag_pkg::oper_t e;
    int c;
    e = '0;
    e.valid = 1'b1;
    e.op = o;
    e.addr = a;
    c = 0;
    for (int g = 4; g >= 1; g--) begin
      if (s[4-g]) begin
        e.sel[g] = 1'b1;
        e.word_addr[g] = a - 15'(c);
        e.sign_src[g] = (c == 0);
        e.ovf_reg = '0;
        e.ovf_reg[g] = 1'b1;
        c++;
      end
    end
    e.extra = 4'(c - 1);
    return e;
  endfunction

  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    lat = 4'h0;
    err_count = 0;
    checks_done = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped", {er, rd}, {1'b1, 32'h0});
    apb(1'b1, `OAG_INT_EN, 32'h1);
    for (int k = 1; k < 16; k++) begin
      idx[k] = 15'h7E00 | 15'(k);
      apb(1'b1, 12'h044 + 12'(4 * (k - 1)), 32'(idx[k]));
    end
    // every index select, carry out of bit 15 dropped, absent registers
    for (int x = 0; x < 16; x++) begin
      m = 10'h3FF - 10'(x);
      r = (x == 0) ? 4'hF : 4'(x);
      op = 6'(x * 4 + 3);
      ins = {1'b0, 4'(x), op, r, m};
      ea = (x == 0) ? 15'(m) : (x >= 10) ? 15'(m) + 15'h7FFF : 15'(m) + idx[x];
      run(ins, 1'b0);
      chk("edges", n, 1);
      chk("oper", oper_out, exp_oper(op, ea, r));
      apb(1'b0, `OAG_INT_STAT, 32'h0);
      chk("done", {irq, rd[1:0]}, 3'b101);
      apb(1'b1, `OAG_INT_CLR, 32'h1);
    end
    // fitted optional register is really used
    ins = {1'b0, 4'hC, 6'h3F, 4'h1, 10'h005};
    // start indexes with the fitted flag already held, so set it first
    apb(1'b1, `OAG_CTRL, 32'h2);
    run(ins, 1'b1);
    chk("fit15", oper_out, exp_oper(6'h3F, idx[12] + 15'h0005, 4'h1));
    apb(1'b0, 12'h04C, 32'h0);
    chk("idx3", rd, 32'(idx[3]));
    apb(1'b0, `OAG_INSTR, 32'h0);
    chk("instr", rd, 32'(ins));
    apb(1'b1, `OAG_INT_CLR, 32'h3);
    // two-level chain, indexed, slow memory, stray unused bits
    lat <= 4'h3;
    u_core_mem_model.mem[5] = {1'b1, 4'h1, 3'b000, 2'b00, 15'h0208};
    u_core_mem_model.mem[9] = {1'b0, 4'h2, 3'b000, 2'b11, 15'h0010};
    ins = {1'b1, 4'h0, 6'h11, 4'b1010, 10'd5};
    run(ins, 1'b0);
    chk("chain", oper_out, exp_oper(6'h11, idx[2] + 15'h0010, 4'b1010));
    apb(1'b0, `OAG_CHAIN, 32'h0);
    chk("count", rd, 32'h2);
    apb(1'b0, `OAG_RESULT, 32'h0);
    chk("result", rd, 32'(idx[2] + 15'h0010));
    apb(1'b1, `OAG_INT_CLR, 32'h3);
    // field select hand-off, then masking of its event
    lat <= 4'h0;
    u_core_mem_model.mem[7] = {1'b0, 4'h1, 3'b101, 2'b01, 15'h0020};
    apb(1'b1, `OAG_INT_EN, 32'h2);
    run({1'b1, 4'h0, 6'h22, 4'h1, 10'd7}, 1'b0);
    chk("field_select_control_word", {field_select_control_word_out, oper_out.valid}, {1'b1, u_core_mem_model.mem[7], 15'd7, 1'b0});
    apb(1'b0, `OAG_INT_STAT, 32'h0);
    chk("field_select_control_word_ev", {irq, rd[1]}, 2'b11);
    apb(1'b1, `OAG_INT_EN, 32'h0);
    apb(1'b0, `OAG_INT_STAT, 32'h0);
    chk("masked", {irq, rd[1]}, 2'b01);
    apb(1'b1, `OAG_INT_CLR, 32'h3);
    apb(1'b0, `OAG_INT_STAT, 32'h0);
    chk("cleared", rd[1:0], 2'b00);
    // saved counter word reads back with upper bits clear
    apb(1'b1, `OAG_SAVE, 32'hFFFFFFFF);
    apb(1'b0, `OAG_SAVE, 32'h0);
    chk("save", rd, 32'h00007FFF);
    conclude();
  end
endmodule // tb
